/* tap_controller.sv */
// Purpose: sixteen-state test access port controller with ir, bypass,
//          identification and boundary-scan data paths
// Assumes: test clock much slower than clock_i (125 ns vs 10 ns)
// Notes:   test pins are sampled by clock_i; edges of test clock are found
//          from the synchronised copy, so all logic runs on clock_i
`timescale 1ns/1ns
`include "tap_map.svh"

// Notes on behaviour
// - five rising test-clock edges with mode select high reach test-logic-reset
// - controller state overrides the queue logic until it is reset
// - state changes only on test-clock rise, steered by mode select, or on test reset
// - test-logic-reset disables all test logic
// - run-test-idle acts only if the instruction asks; none here do
// - select-dr goes to capture-dr or select-ir by mode select
// - select-ir goes to capture-ir or back to reset by mode select
// - capture-ir loads a fixed pattern ending in 01
// - shift-ir shifts one bit per rise between data in and out
// - exit1-ir goes to pause-ir or update-ir
// - pause-ir holds the instruction shift stages
// - exit2-ir goes back to shift-ir or to update-ir
// - update-ir latches the instruction on the falling edge
// - capture-dr loads the selected data register on the rise
// - data-path states mirror the instruction path on the selected register
// - port has clock, mode, data in, active-low reset and data out
// - instruction register is four bits wide
// - decode: 0,1 boundary; 2 identification; 3 float plus bypass; F bypass
// - bypass stage clears to zero in capture-dr when selected
// - 32-bit read-only identification with bit 0 one
module tap_controller
  import tap_pkg::*;
#(
  parameter int BSCAN_LEN = 8
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  input  wire logic                 trst_b_i,
  input  wire logic [BSCAN_LEN-1:0] pins_in_i,
  output logic                      tdo_o,
  output logic                      tdo_oe_b_o,
  output logic                      test_active_o,
  output logic                      drive_pins_o,
  output logic                      float_pins_o,
  output logic [BSCAN_LEN-1:0]      pins_out_o
);

  // refused at elaboration: an empty chain leaves the shift path undefined
  if (BSCAN_LEN < 1) begin : g_len_check
    $error("boundary chain length must be at least one");
  end

  // ----------------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------------
  logic       rst_s1_q, rst_q;
  logic [3:0] pin_s1_q, pin_s2_q;
  logic       tck_prev_q;

  // release of the system reset through two flops
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  // test pins pass two flops; first stage feeds only the second
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      pin_s1_q   <= 4'h0;
      pin_s2_q   <= 4'h0;
      tck_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= {trst_b_i, tdi_i, tms_i, tck_i};
      pin_s2_q   <= pin_s1_q;
      tck_prev_q <= pin_s2_q[0];
    end
  end

  wire tck_s   = pin_s2_q[0];
  wire tms_s   = pin_s2_q[1];
  wire tdi_s   = pin_s2_q[2];
  wire trst_s  = ~pin_s2_q[3];
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;

  // ----------------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------------
  tap_state_t state_q, state_d;

  // next state from mode select; every arc of the standard diagram
  always_comb begin
    state_d = state_q;
    case (state_q)
      TLR:    state_d = tms_s ? TLR    : RTI;
      RTI:    state_d = tms_s ? SEL_DR : RTI;
      SEL_DR: state_d = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: state_d = tms_s ? EX1_DR : SH_DR;
      SH_DR:  state_d = tms_s ? EX1_DR : SH_DR;
      EX1_DR: state_d = tms_s ? UPD_DR : PA_DR;
      PA_DR:  state_d = tms_s ? EX2_DR : PA_DR;
      EX2_DR: state_d = tms_s ? UPD_DR : SH_DR;
      UPD_DR: state_d = tms_s ? SEL_DR : RTI;
      SEL_IR: state_d = tms_s ? TLR    : CAP_IR;
      CAP_IR: state_d = tms_s ? EX1_IR : SH_IR;
      SH_IR:  state_d = tms_s ? EX1_IR : SH_IR;
      EX1_IR: state_d = tms_s ? UPD_IR : PA_IR;
      PA_IR:  state_d = tms_s ? EX2_IR : PA_IR;
      EX2_IR: state_d = tms_s ? UPD_IR : SH_IR;
      UPD_IR: state_d = tms_s ? SEL_DR : RTI;
      default: state_d = TLR;
    endcase
  end

  // test reset wins; with no reset the system reset only defines sim state,
  // the host must still reset the port itself
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= TLR;
    end else if (trst_s) begin
      state_q <= TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------------
  logic [`IR_WIDTH-1:0] ir_sh_q, ir_q;

  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      ir_sh_q <= `IR_CAPTURE;
      ir_q    <= `INS_IDCODE;
    end else if (trst_s || state_q == TLR) begin
      ir_sh_q <= `IR_CAPTURE;
      ir_q    <= `INS_IDCODE;
    end else begin
      if (tck_rise && state_q == CAP_IR)
        ir_sh_q <= `IR_CAPTURE;
      else if (tck_rise && state_q == SH_IR)
        ir_sh_q <= {tdi_s, ir_sh_q[`IR_WIDTH-1:1]};
      // pause and exit states leave the stages alone
      if (tck_fall && state_q == UPD_IR)
        ir_q <= ir_sh_q;
    end
  end

  // decode of the current instruction
  function automatic dr_path_t decode_path(input logic [`IR_WIDTH-1:0] ins);
    case (ins)
      `INS_EXTEST, `INS_SAMPLE: decode_path = PATH_BSCAN;
      `INS_IDCODE:              decode_path = PATH_IDENT;
      default:                  decode_path = PATH_BYPASS;
    endcase
  endfunction

  wire dr_path_t path     = decode_path(ir_q);
  wire           in_reset = (state_q == TLR);
  wire           extest   = ~in_reset & (ir_q == `INS_EXTEST);
  wire           highz    = ~in_reset & (ir_q == `INS_HIGHZ);

  // ----------------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------------
  localparam logic [31:0] ID_VALUE = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};
  logic                 byp_q;
  logic [31:0]          id_q;
  logic [BSCAN_LEN-1:0] bs_sh_q, bs_upd_q;

  wire cap_dr = tck_rise && state_q == CAP_DR;
  wire sh_dr  = tck_rise && state_q == SH_DR;

  // capture, shift and update per selected path
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      byp_q    <= 1'b0;
      id_q     <= 32'h00000000;
      bs_sh_q  <= '0;
      bs_upd_q <= '0;
    end else begin
      if (path == PATH_BYPASS) begin
        if (cap_dr) byp_q <= 1'b0;
        else if (sh_dr) byp_q <= tdi_s;
      end
      if (path == PATH_IDENT) begin
        if (cap_dr) id_q <= ID_VALUE;
        else if (sh_dr) id_q <= {tdi_s, id_q[31:1]};
      end
      if (path == PATH_BSCAN) begin
        if (cap_dr) bs_sh_q <= pins_in_i;
        else if (sh_dr) bs_sh_q <= {tdi_s, bs_sh_q[BSCAN_LEN-1:1]};
        if (tck_fall && state_q == UPD_DR)
          bs_upd_q <= bs_sh_q;
      end
    end
  end

  // serial out source
  wire dr_bit = (path == PATH_IDENT) ? id_q[0] :
                (path == PATH_BSCAN) ? bs_sh_q[0] : byp_q;
  wire shifting = (state_q == SH_IR) || (state_q == SH_DR);

  // ----------------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------------
  // data out moves on the falling edge, so the host samples a stable bit
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      tdo_o         <= 1'b0;
      tdo_oe_b_o    <= 1'b1;
      test_active_o <= 1'b0;
      drive_pins_o  <= 1'b0;
      float_pins_o  <= 1'b0;
      pins_out_o    <= '0;
    end else begin
      if (tck_fall) begin
        tdo_o      <= (state_q == SH_IR) ? ir_sh_q[0] : dr_bit;
        tdo_oe_b_o <= ~shifting;
      end
      if (trst_s) tdo_oe_b_o <= 1'b1;
      // run-test-idle needs no action: no self test instruction exists
      test_active_o <= extest | highz;
      drive_pins_o  <= extest;
      float_pins_o  <= highz;
      pins_out_o    <= bs_upd_q;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [2:0] ones_q;
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) ones_q <= 3'h0;
    else if (tck_rise) ones_q <= tms_s ? ((ones_q == 3'h5) ? ones_q : ones_q + 3'h1) : 3'h0;
  end

  property p_five_ones;
    @(posedge clock_i) disable iff (!rst_q)
      (ones_q == 3'h5) |-> (state_q == TLR);
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("no reset after five ones");

  property p_steady;
    @(posedge clock_i) disable iff (!rst_q)
      (!tck_rise && !trst_s) |=> $stable(state_q);
  endproperty
  a_steady: assert property (p_steady) else $error("state moved off a rise");

  property p_sel_dr;
    @(posedge clock_i) disable iff (!rst_q || trst_s)
      (tck_rise && state_q == SEL_DR && !tms_s) |=> (state_q == CAP_DR);
  endproperty
  a_sel_dr: assert property (p_sel_dr) else $error("select-dr arc wrong");

  property p_sel_ir;
    @(posedge clock_i) disable iff (!rst_q || trst_s)
      (tck_rise && state_q == SEL_IR && tms_s) |=> (state_q == TLR);
  endproperty
  a_sel_ir: assert property (p_sel_ir) else $error("select-ir arc wrong");

  property p_cap_ir;
    @(posedge clock_i) disable iff (!rst_q || trst_s)
      (tck_rise && state_q == CAP_IR) |=> (ir_sh_q[1:0] == 2'b01);
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("ir capture pattern wrong");

  property p_pause_ir;
    @(posedge clock_i) disable iff (!rst_q || trst_s)
      (state_q == PA_IR) |=> $stable(ir_sh_q);
  endproperty
  a_pause_ir: assert property (p_pause_ir) else $error("ir moved in pause");

  property p_byp;
    @(posedge clock_i) disable iff (!rst_q || trst_s)
      (cap_dr && path == PATH_BYPASS) |=> !byp_q;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass not cleared");

  property p_tdo_off;
    @(posedge clock_i) disable iff (!rst_q)
      (tck_fall && !shifting) |=> tdo_oe_b_o;
  endproperty
  a_tdo_off: assert property (p_tdo_off) else $error("data out driven outside shift");

  property p_trst;
    @(posedge clock_i) disable iff (!rst_q)
      trst_s |=> (state_q == TLR && ir_q == `INS_IDCODE);
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");

  c_ir_update: cover property (@(posedge clock_i) tck_fall && state_q == UPD_IR);
  c_dr_shift:  cover property (@(posedge clock_i) sh_dr && path == PATH_IDENT);
  c_pause_dr:  cover property (@(posedge clock_i) state_q == PA_DR);
  c_extest:    cover property (@(posedge clock_i) drive_pins_o);

endmodule

/* tap_host.sv */
// Purpose: behavioural test host driving the test access port pins
// Assumes: test clock period 125 ns, stands low between frames
// Notes:   data out is read as a pulled-up line while not driven
`timescale 1ns/1ns
module tap_host (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_b_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_b_i
);
  // ----------------------------------------
  // pin state at power-up
  // ----------------------------------------
  initial begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b0;
    trst_b_o = 1'b0;            // held in test reset from power-up
  end
  // pulsed reset; the host must do this before the queues are used
  task automatic treset();
    trst_b_o = 1'b0;
    #100;
    trst_b_o = 1'b1;
    #100;
  endtask
  // one test clock: mode and data set while low, data out read before the rise
  task automatic pulse(input logic tms, input logic tdi, output logic tdo, output logic oe_b);
    tms_o = tms;                // steers the next state at the rise
    tdi_o = tdi;
    #63;
    tdo   = tdo_oe_b_i ? 1'b1 : tdo_i;   // undriven line floats to the pull-up
    oe_b  = tdo_oe_b_i;
    tck_o = 1'b1;
    #62;
    tck_o = 1'b0;
  endtask
endmodule

/* tap_map.svh */
// Purpose: constants for the boundary-scan test access port controller
// Assumes: included by the controller and the bench
// Notes:   definitions only
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
`define IR_WIDTH        4
`define IR_CAPTURE      4'h1
`define INS_EXTEST      4'h0
`define INS_SAMPLE      4'h1
`define INS_IDCODE      4'h2
`define INS_HIGHZ       4'h3
`define INS_BYPASS      4'hF
`define ID_VERSION      4'h0
`define ID_PART         16'h1234
`define ID_MAKER        11'h055
`define TMS_RESET_COUNT 5
`define SYNC_STAGES     2
`endif

/* tap_pkg.sv */
// Purpose: types for the test access port controller
// Assumes: nothing
// Notes:   state encoding left to synthesis
package tap_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;
  typedef enum logic [1:0] {
    PATH_BYPASS, PATH_IDENT, PATH_BSCAN
  } dr_path_t;
endpackage

/* tb_top.sv */
// Purpose: self-checking bench for the test access port controller
// Assumes: host model drives the test pins at a 125 ns period
// Notes:   chain shorter than a real part keeps the run brief
`timescale 1ns/1ns
`include "tap_map.svh"
module tb_top;
  import tap_pkg::*;
  logic       clock_i, rst_b_i, tck, tms, tdi, trst_b, tdo, tdo_oe_b;
  logic       test_active, drive_pins, float_pins;
  logic [7:0] pins_in, pins_out;
  int         n_errors, compares;
  logic [31:0] id_exp, got;
  tap_host host_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_b_o(trst_b),
                      .tdo_i(tdo), .tdo_oe_b_i(tdo_oe_b));
  tap_controller #(.BSCAN_LEN(8)) tap_controller_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_b_i(trst_b), .pins_in_i(pins_in), .tdo_o(tdo), .tdo_oe_b_o(tdo_oe_b),
    .test_active_o(test_active), .drive_pins_o(drive_pins), .float_pins_o(float_pins),
    .pins_out_o(pins_out));
  // ----------------------------------------
  // checking and ending
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // scan from run-test-idle back to run-test-idle; pause splits the shift after bit 1
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input logic pause, output logic [31:0] dout);
    logic t, e;
    dout = '0;
    host_inst.pulse(1'b1, 1'b0, t, e);
    if (ir) host_inst.pulse(1'b1, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b0, t, e);
    for (int i = 0; i < n; i++) begin
      host_inst.pulse((i == n - 1) || (pause && i == 1), din[i], t, e);
      dout[i] = t;
      chk("oe_b in shift", 32'h0, {31'h0, e});
      if (pause && i == 1) begin
        host_inst.pulse(1'b0, ~din[i], t, e);
        host_inst.pulse(1'b0, ~din[i], t, e);
        chk("oe_b in pause", 32'h1, {31'h0, e});
        host_inst.pulse(1'b1, ~din[i], t, e);
        host_inst.pulse(1'b0, ~din[i], t, e);
      end
    end
    host_inst.pulse(1'b1, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b0, t, e);
    #100;
    chk("oe_b in idle", 32'h1, {31'h0, tdo_oe_b});
  endtask
  task automatic ir_load(input logic [3:0] code);
    scan(1'b1, 4, {28'h0, code}, 1'b0, got);
    chk("ir capture", 32'h1, got);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idcode();
    logic t, e;
    host_inst.treset();
    chk("active in reset", 32'h0, {31'h0, test_active});
    // reset leaves the port in test-logic-reset; one low mode bit reaches idle
    host_inst.pulse(1'b0, 1'b0, t, e);
    scan(1'b0, 32, 32'h0, 1'b0, got);
    chk("identification", id_exp, got);
  endtask
  task automatic t_bypass();
    scan(1'b1, 4, 32'hF, 1'b1, got);
    chk("ir capture paused", 32'h1, got);
    scan(1'b0, 8, 32'hA5, 1'b0, got);
    chk("bypass out", 32'h4A, got);
  endtask
  task automatic t_highz();
    ir_load(`INS_HIGHZ);
    chk("float", 32'h1, {31'h0, float_pins});
    chk("active highz", 32'h1, {31'h0, test_active});
    scan(1'b0, 8, 32'h3C, 1'b0, got);
    chk("highz bypass", 32'h78, got);
  endtask
  task automatic t_extest();
    ir_load(`INS_EXTEST);
    chk("drive", 32'h1, {31'h0, drive_pins});
    chk("float off", 32'h0, {31'h0, float_pins});
    scan(1'b0, 8, 32'h5A, 1'b1, got);
    chk("boundary capture", 32'hC3, got);
    chk("boundary update", 32'h5A, {24'h0, pins_out});
  endtask
  task automatic t_sample();
    ir_load(`INS_SAMPLE);
    chk("sample drive", 32'h0, {31'h0, drive_pins});
    chk("sample active", 32'h0, {31'h0, test_active});
    scan(1'b0, 8, 32'h96, 1'b0, got);
    chk("sample capture", 32'hC3, got);
    chk("preload", 32'h96, {24'h0, pins_out});
  endtask
  task automatic t_tms_reset();
    logic t, e;
    ir_load(`INS_EXTEST);
    // start from shift-dr, the deepest point: all five ones are then needed
    host_inst.pulse(1'b1, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b0, t, e);
    for (int i = 0; i < 5; i++) host_inst.pulse(1'b1, 1'b0, t, e);
    #100;
    chk("drive after tms reset", 32'h0, {31'h0, drive_pins});
    host_inst.pulse(1'b0, 1'b0, t, e);
    scan(1'b0, 32, 32'h0, 1'b0, got);
    chk("id after tms reset", id_exp, got);
  endtask
  // test reset in the middle of a data shift: output released, pins let go
  task automatic t_trst();
    logic t, e;
    ir_load(`INS_EXTEST);
    host_inst.pulse(1'b1, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b0, t, e);
    host_inst.pulse(1'b0, 1'b1, t, e);
    chk("oe_b before reset", 32'h0, {31'h0, tdo_oe_b});
    chk("drive before reset", 32'h1, {31'h0, drive_pins});
    host_inst.treset();
    chk("oe_b after reset", 32'h1, {31'h0, tdo_oe_b});
    chk("drive after reset", 32'h0, {31'h0, drive_pins});
    host_inst.pulse(1'b0, 1'b0, t, e);
    scan(1'b0, 32, 32'h0, 1'b0, got);
    chk("id after test reset", id_exp, got);
  endtask
  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    rst_b_i  = 1'b0;
    pins_in  = 8'hC3;
    n_errors = 0;
    compares = 0;
    id_exp   = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};
    repeat (3) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    repeat (10) @(posedge clock_i);
    #1;                           // keeps every host pin change off the clock edge
    t_idcode();
    t_bypass();
    t_highz();
    t_extest();
    t_sample();
    t_tms_reset();
    t_trst();
    test_done();
  end
  // scans total well under 60 us; a hang is cut at 200 us
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule
